// ===== include/xscc_pkg.sv
// package: constants and types for the x21 switched call control block
// Summary of operation
// - monitor open completes when dce matches target
// - close: housekeeping only if already cleared
// - close normal only if clean clear, no compare error
// - adapter reset before any close completion
// - close leaves interface controlled-not-ready
// - halt aborts open, then clears line
// - never call request after incoming call seen
// - other cp first digits only start rfd timer if off
// - cp digit 0: 60 s wait, cp status
// - cp digit 2/6: clear, buffer, retry status
// - enter call ready via open-for-incoming
// - dce not ready: reminder, monitor, then ready
// - bell status, incoming then in-use indicator
// - dial: halt, home cursor, wait, dial-in
// - enter: outgoing open with selection signals
// - direct: halt, outgoing open without selection
// - ready for data: in-use, data exchange
// - local: halt, not ready; communicate reopens
// - disconnect key: close or halt, then ready
// - timeout or link disconnect drops line
// - keys accepted or ignored per state
`default_nettype none
package xscc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int ADW = 8;
	localparam logic [7:0] OFS_KEY = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_SEL = 8'h08;
	localparam logic [7:0] OFS_CPB = 8'h0C;
	localparam logic [7:0] OFS_CFG = 8'h10;
	localparam logic [2:0] SZ_WORD = 3'h2;
	localparam logic CFG_MON_RST = 1'b1;
	// ----------------------------------------
	// key and indicator bits
	// ----------------------------------------
	localparam int NKEY = 6;
	localparam int K_DIAL = 0;
	localparam int K_DIRECT = 1;
	localparam int K_DISCONNECT_KEY = 2;
	localparam int K_LOCAL = 3;
	localparam int K_COMM = 4;
	localparam int K_ENTER = 5;
	localparam int NIND = 9;
	localparam int I_READY = 0;
	localparam int I_WAIT = 1;
	localparam int I_DIAL = 2;
	localparam int I_OUT = 3;
	localparam int I_IN = 4;
	localparam int I_USE = 5;
	localparam int I_DISCONNECT_KEY = 6;
	localparam int I_LOCAL = 7;
	localparam int I_CERR = 8;
	// ----------------------------------------
	// call progress and timing
	// ----------------------------------------
	localparam int CP_D1_LSB = 4;
	localparam int CP_DW = 4;
	localparam logic [3:0] CP_WAIT = 4'h0;
	localparam logic [3:0] CP_RETRY_A = 4'h2;
	localparam logic [3:0] CP_RETRY_B = 4'h6;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned T_RFD_S = 2;
	localparam int unsigned T_CPW_S = 60;
	localparam int unsigned T_CLR_S = 2;
	// ----------------------------------------
	// function requests and completions
	// ----------------------------------------
	typedef enum logic [2:0] {
		FR_NONE, FR_OPEN_IN, FR_OPEN_OUT, FR_MON, FR_CLOSE, FR_HALT
	} xscc_fr_t;
	typedef enum logic [2:0] {
		CC_NORMAL, CC_ERROR, CC_BEL, CC_CP, CC_RETRY
	} xscc_cc_t;
endpackage : xscc_pkg
`default_nettype wire

// ===== src/xscc_top.sv
// module: x21 switched call sequencer, link control and register slave
`default_nettype none
module xscc_top #(
	parameter int unsigned RFD_CYC = xscc_pkg::T_RFD_S * xscc_pkg::CLK_HZ,
	parameter int unsigned CPW_CYC = xscc_pkg::T_CPW_S * xscc_pkg::CLK_HZ,
	parameter int unsigned CLR_CYC = xscc_pkg::T_CLR_S * xscc_pkg::CLK_HZ
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// x21 line status
	input wire logic i_dce_ready,
	input wire logic i_bell,
	input wire logic i_rfd,
	input wire logic i_cp_valid,
	input wire logic [7:0] i_cp_code,
	input wire logic i_clear_done,
	input wire logic i_cmp_err,
	// link level events
	input wire logic i_link_disconnect_key,
	input wire logic i_link_tmo,
	// x21 line control
	output logic o_call_req,
	output logic o_call_acc,
	output logic o_sel_en,
	output logic [31:0] o_sel_data,
	output logic o_clear_req,
	output logic o_adapter_rst,
	output logic o_cnr,
	output logic o_data_phase,
	// operator display
	output logic [xscc_pkg::NIND-1:0] o_ind,
	output logic o_home_cursor
);
	// ----------------------------------------
	// types and state
	// ----------------------------------------
	typedef enum logic [2:0] {
		SQ_IDLE, SQ_MON, SQ_IN, SQ_ACC, SQ_OUT, SQ_CLR, SQ_RST, SQ_POST
	} xscc_sq_t;
	typedef enum logic [3:0] {
		LC_START, LC_MON, LC_READY, LC_HDIAL, LC_DIAL, LC_HDIR,
		LC_HLOC, LC_LOCAL, LC_OUT, LC_IN, LC_DATA, LC_DISCONNECT_KEY
	} xscc_lc_t;

	xscc_sq_t sq_reg, sq_next;
	xscc_lc_t lc_reg, lc_next;
	xscc_pkg::xscc_fr_t frc_reg, frc_next, fr_code;
	xscc_pkg::xscc_cc_t fc_reg, fc_next, cc_code, last_cc_reg;
	logic [31:0] tmr_reg, tmr_next;
	logic ton_reg, ton_next;
	logic data_reg, data_next;
	logic cnr_reg, cnr_next;
	logic clrd_reg, clrd_next;
	logic [7:0] cpb_reg, cpb_next;
	logic cerr_reg, cerr_next;
	logic sel_en_reg, sel_set;
	logic [31:0] sel_reg;
	logic mon_tgt_reg;
	logic last_fin_reg;
	logic [xscc_pkg::NIND-1:0] ind_reg, ind_w;
	logic home_reg;
	logic dph_reg, wr_reg;
	logic [xscc_pkg::ADW-1:0] adr_reg;
	logic [31:0] rdat_reg;
	logic cc_v, cc_fin, fr_go;

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	wire logic aph_w;
	wire logic [xscc_pkg::ADW-1:0] a_w;
	wire logic wr_ph;
	wire logic [31:0] stat_w;
	wire logic [31:0] rd_w;
	wire logic [xscc_pkg::NKEY-1:0] key_w;
	assign aph_w = i_hsel && i_hready && i_htrans[1];
	assign a_w = i_haddr[xscc_pkg::ADW-1:0];
	assign wr_ph = dph_reg && wr_reg;
	assign stat_w = {8'h00, lc_reg, last_fin_reg, last_cc_reg, data_reg,
		o_cnr, sq_reg, 1'b0, 1'b0, ind_reg};
	assign rd_w = (a_w == xscc_pkg::OFS_STAT) ? stat_w :
		(a_w == xscc_pkg::OFS_SEL) ? sel_reg :
		(a_w == xscc_pkg::OFS_CPB) ? {24'h000000, cpb_reg} :
		(a_w == xscc_pkg::OFS_CFG) ? {31'h00000000, mon_tgt_reg} : 32'h00000000;
	assign key_w = (wr_ph && adr_reg == xscc_pkg::OFS_KEY) ?
		i_hwdata[xscc_pkg::NKEY-1:0] : '0;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdat_reg;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dph_reg <= 1'b0;
			wr_reg <= 1'b0;
			adr_reg <= '0;
			rdat_reg <= 32'h00000000;
			sel_reg <= 32'h00000000;
			mon_tgt_reg <= xscc_pkg::CFG_MON_RST;
		end else begin
			dph_reg <= aph_w;
			wr_reg <= aph_w && i_hwrite && i_hsize == xscc_pkg::SZ_WORD;
			adr_reg <= a_w;
			if (aph_w && !i_hwrite)
				rdat_reg <= rd_w;
			if (wr_ph && adr_reg == xscc_pkg::OFS_SEL)
				sel_reg <= i_hwdata;
			if (wr_ph && adr_reg == xscc_pkg::OFS_CFG)
				mon_tgt_reg <= i_hwdata[0];
		end
	end

	// ----------------------------------------
	// call sequencer
	// ----------------------------------------
	wire logic sq_idle_w;
	wire logic tmo_w;
	wire logic [3:0] cpd_w;
	wire logic fin_w;
	assign sq_idle_w = sq_reg == SQ_IDLE || sq_reg == SQ_POST;
	assign tmo_w = ton_reg && tmr_reg == 32'h00000000;
	assign cpd_w = i_cp_code[xscc_pkg::CP_D1_LSB +: xscc_pkg::CP_DW];
	assign fin_w = cc_v && cc_fin;

	always_comb begin
		sq_next = sq_reg;
		fc_next = fc_reg;
		frc_next = frc_reg;
		tmr_next = (tmr_reg != 32'h00000000) ? tmr_reg - 32'h00000001 : tmr_reg;
		ton_next = ton_reg;
		data_next = data_reg;
		cnr_next = cnr_reg;
		clrd_next = clrd_reg;
		cpb_next = cpb_reg;
		cc_v = 1'b0;
		cc_fin = 1'b0;
		cc_code = xscc_pkg::CC_NORMAL;
		case (sq_reg)
			SQ_IDLE: begin
			end
			SQ_POST: begin
				cc_v = 1'b1;
				cc_fin = 1'b1;
				cc_code = fc_reg;
				sq_next = SQ_IDLE;
			end
			SQ_MON: begin
				if (i_dce_ready == mon_tgt_reg) begin
					fc_next = xscc_pkg::CC_NORMAL;
					sq_next = SQ_POST;
				end
			end
			SQ_IN: begin
				if (i_bell) begin
					cc_v = 1'b1;
					cc_code = xscc_pkg::CC_BEL;
					clrd_next = 1'b0;
					tmr_next = RFD_CYC;
					ton_next = 1'b1;
					sq_next = SQ_ACC;
				end
			end
			SQ_ACC: begin
				if (i_rfd) begin
					data_next = 1'b1;
					ton_next = 1'b0;
					fc_next = xscc_pkg::CC_NORMAL;
					sq_next = SQ_POST;
				end else if (tmo_w) begin
					fc_next = xscc_pkg::CC_ERROR;
					tmr_next = CLR_CYC;
					sq_next = SQ_CLR;
				end
			end
			SQ_OUT: begin
				if (i_rfd) begin
					data_next = 1'b1;
					ton_next = 1'b0;
					fc_next = xscc_pkg::CC_NORMAL;
					sq_next = SQ_POST;
				end else if (i_cp_valid) begin
					cpb_next = i_cp_code;
					if (cpd_w == xscc_pkg::CP_WAIT) begin
						cc_v = 1'b1;
						cc_code = xscc_pkg::CC_CP;
						tmr_next = CPW_CYC;
						ton_next = 1'b1;
					end else if (cpd_w == xscc_pkg::CP_RETRY_A ||
						cpd_w == xscc_pkg::CP_RETRY_B) begin
						cc_v = 1'b1;
						cc_code = xscc_pkg::CC_RETRY;
						fc_next = xscc_pkg::CC_ERROR;
						tmr_next = CLR_CYC;
						ton_next = 1'b1;
						sq_next = SQ_CLR;
					end else if (!ton_reg) begin
						tmr_next = RFD_CYC;
						ton_next = 1'b1;
					end
				end else if (tmo_w) begin
					fc_next = xscc_pkg::CC_ERROR;
					tmr_next = CLR_CYC;
					sq_next = SQ_CLR;
				end
			end
			SQ_CLR: begin
				if (i_cmp_err || tmo_w) begin
					fc_next = xscc_pkg::CC_ERROR;
					ton_next = 1'b0;
					sq_next = SQ_RST;
				end else if (i_clear_done) begin
					ton_next = 1'b0;
					sq_next = SQ_RST;
				end
			end
			SQ_RST: begin
				clrd_next = 1'b1;
				if (frc_reg == xscc_pkg::FR_CLOSE)
					cnr_next = 1'b1;
				sq_next = SQ_POST;
			end
			default: begin
				sq_next = SQ_IDLE;
			end
		endcase
		if (fr_go && fr_code == xscc_pkg::FR_HALT) begin
			frc_next = fr_code;
			fc_next = xscc_pkg::CC_NORMAL;
			data_next = 1'b0;
			tmr_next = CLR_CYC;
			ton_next = 1'b1;
			sq_next = SQ_CLR;
		end else if (fr_go && sq_idle_w && fr_code != xscc_pkg::FR_NONE) begin
			frc_next = fr_code;
			fc_next = xscc_pkg::CC_NORMAL;
			ton_next = 1'b0;
			case (fr_code)
				xscc_pkg::FR_OPEN_IN: begin
					cnr_next = 1'b0;
					if (!i_dce_ready) begin
						fc_next = xscc_pkg::CC_ERROR;
						sq_next = SQ_POST;
					end else begin
						sq_next = SQ_IN;
					end
				end
				xscc_pkg::FR_OPEN_OUT: begin
					cnr_next = 1'b0;
					clrd_next = 1'b0;
					sq_next = SQ_OUT;
				end
				xscc_pkg::FR_MON: begin
					sq_next = SQ_MON;
				end
				xscc_pkg::FR_CLOSE: begin
					data_next = 1'b0;
					tmr_next = CLR_CYC;
					ton_next = !clrd_reg;
					sq_next = clrd_reg ? SQ_RST : SQ_CLR;
				end
				default: begin
					sq_next = sq_reg;
				end
			endcase
		end
	end

	// ----------------------------------------
	// link control and key handling
	// ----------------------------------------
	always_comb begin
		lc_next = lc_reg;
		fr_go = 1'b0;
		fr_code = xscc_pkg::FR_NONE;
		sel_set = 1'b0;
		cerr_next = cerr_reg;
		if (fin_w && cc_code == xscc_pkg::CC_ERROR)
			cerr_next = 1'b1;
		case (lc_reg)
			LC_START: begin
				if (sq_idle_w && i_dce_ready) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_OPEN_IN;
					lc_next = LC_READY;
				end else if (sq_idle_w) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_MON;
					cerr_next = 1'b1;
					lc_next = LC_MON;
				end
			end
			LC_MON: begin
				if (fin_w && cc_code == xscc_pkg::CC_NORMAL) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_OPEN_IN;
					lc_next = LC_READY;
				end else if (fin_w) begin
					lc_next = LC_START;
				end
			end
			LC_READY: begin
				if (fin_w) begin
					lc_next = LC_START;
				end else if (cc_v && cc_code == xscc_pkg::CC_BEL) begin
					lc_next = LC_IN;
				end else if (key_w[xscc_pkg::K_DIAL]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_HALT;
					lc_next = LC_HDIAL;
				end else if (key_w[xscc_pkg::K_DIRECT]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_HALT;
					lc_next = LC_HDIR;
				end else if (key_w[xscc_pkg::K_LOCAL]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_HALT;
					lc_next = LC_HLOC;
				end else if (key_w[xscc_pkg::K_COMM]) begin
					cerr_next = 1'b0;
				end
			end
			LC_HDIAL: begin
				if (fin_w)
					lc_next = LC_DIAL;
			end
			LC_DIAL: begin
				if (key_w[xscc_pkg::K_ENTER]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_OPEN_OUT;
					sel_set = 1'b1;
					lc_next = LC_OUT;
				end
			end
			LC_HDIR: begin
				if (fin_w) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_OPEN_OUT;
					lc_next = LC_OUT;
				end
			end
			LC_HLOC: begin
				if (fin_w)
					lc_next = LC_LOCAL;
			end
			LC_LOCAL: begin
				if (key_w[xscc_pkg::K_COMM]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_OPEN_IN;
					lc_next = LC_READY;
				end
			end
			LC_OUT, LC_IN: begin
				if (fin_w && cc_code == xscc_pkg::CC_NORMAL) begin
					lc_next = LC_DATA;
				end else if (fin_w) begin
					lc_next = LC_START;
				end else if (key_w[xscc_pkg::K_DISCONNECT_KEY]) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_HALT;
					lc_next = LC_DISCONNECT_KEY;
				end
			end
			LC_DATA: begin
				if (key_w[xscc_pkg::K_DISCONNECT_KEY] || i_link_disconnect_key || i_link_tmo) begin
					fr_go = 1'b1;
					fr_code = xscc_pkg::FR_CLOSE;
					lc_next = LC_DISCONNECT_KEY;
				end
			end
			LC_DISCONNECT_KEY: begin
				if (fin_w)
					lc_next = LC_START;
			end
			default: begin
				lc_next = LC_START;
			end
		endcase
	end

	// ----------------------------------------
	// indicators from the next link state
	// ----------------------------------------
	always_comb begin
		ind_w = '0;
		ind_w[xscc_pkg::I_CERR] = cerr_next;
		case (lc_next)
			LC_READY: ind_w[xscc_pkg::I_READY] = 1'b1;
			LC_HDIAL: ind_w[xscc_pkg::I_WAIT] = 1'b1;
			LC_DIAL: ind_w[xscc_pkg::I_DIAL] = 1'b1;
			LC_HDIR, LC_OUT: ind_w[xscc_pkg::I_OUT] = 1'b1;
			LC_IN: ind_w[xscc_pkg::I_IN] = 1'b1;
			LC_DATA: ind_w[xscc_pkg::I_USE] = 1'b1;
			LC_DISCONNECT_KEY: ind_w[xscc_pkg::I_DISCONNECT_KEY] = 1'b1;
			LC_HLOC, LC_LOCAL: ind_w[xscc_pkg::I_LOCAL] = 1'b1;
			default: ind_w[xscc_pkg::I_WAIT] = 1'b0;
		endcase
	end

	assign o_call_req = sq_reg == SQ_OUT;
	assign o_call_acc = sq_reg == SQ_ACC;
	assign o_sel_en = o_call_req && sel_en_reg;
	assign o_sel_data = sel_reg;
	assign o_clear_req = sq_reg == SQ_CLR;
	assign o_adapter_rst = sq_reg == SQ_RST;
	assign o_cnr = cnr_reg || lc_reg == LC_LOCAL;
	assign o_data_phase = data_reg;
	assign o_ind = ind_reg;
	assign o_home_cursor = home_reg;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sq_reg <= SQ_IDLE;
			lc_reg <= LC_START;
			frc_reg <= xscc_pkg::FR_NONE;
			fc_reg <= xscc_pkg::CC_NORMAL;
			last_cc_reg <= xscc_pkg::CC_NORMAL;
			last_fin_reg <= 1'b0;
			tmr_reg <= 32'h00000000;
			ton_reg <= 1'b0;
			data_reg <= 1'b0;
			cnr_reg <= 1'b1;
			clrd_reg <= 1'b1;
			cpb_reg <= 8'h00;
			cerr_reg <= 1'b0;
			sel_en_reg <= 1'b0;
			ind_reg <= '0;
			home_reg <= 1'b0;
		end else begin
			sq_reg <= sq_next;
			lc_reg <= lc_next;
			frc_reg <= frc_next;
			fc_reg <= fc_next;
			tmr_reg <= tmr_next;
			ton_reg <= ton_next;
			data_reg <= data_next;
			cnr_reg <= cnr_next;
			clrd_reg <= clrd_next;
			cpb_reg <= cpb_next;
			cerr_reg <= cerr_next;
			ind_reg <= ind_w;
			home_reg <= lc_reg == LC_READY && lc_next == LC_HDIAL;
			if (fr_go && fr_code == xscc_pkg::FR_OPEN_OUT)
				sel_en_reg <= sel_set;
			if (cc_v) begin
				last_cc_reg <= cc_code;
				last_fin_reg <= cc_fin;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking dc @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_rst_post;
		o_adapter_rst ##1 (cc_v && cc_fin);
	endsequence

	AST_MON_DONE: assert property (
		sq_reg == SQ_MON && i_dce_ready == mon_tgt_reg && !fr_go
		|=> cc_v && cc_fin && cc_code == xscc_pkg::CC_NORMAL)
		else $error("monitor open did not complete");
	AST_CLOSE_SHORT: assert property (
		fr_go && fr_code == xscc_pkg::FR_CLOSE && sq_idle_w && clrd_reg
		|=> o_adapter_rst && !o_clear_req)
		else $error("close on cleared line started clearing");
	AST_CLR_ERR: assert property (
		o_clear_req && i_cmp_err && !fr_go
		|=> s_rst_post ##0 cc_code == xscc_pkg::CC_ERROR)
		else $error("compare error not reported");
	AST_RST_FIRST: assert property (
		cc_v && cc_fin && frc_reg == xscc_pkg::FR_CLOSE |-> $past(o_adapter_rst))
		else $error("close completed without adapter reset");
	AST_CNR: assert property (
		cc_v && cc_fin && frc_reg == xscc_pkg::FR_CLOSE && !fr_go |=> o_cnr)
		else $error("close did not leave not ready");
	AST_HALT: assert property (
		fr_go && fr_code == xscc_pkg::FR_HALT |=> o_clear_req && !o_call_req)
		else $error("halt did not clear");
	AST_NO_COLLIDE: assert property (
		fr_go && fr_code == xscc_pkg::FR_OPEN_OUT |-> sq_idle_w)
		else $error("outgoing open over pending open");
	AST_CP_WAIT: assert property (
		o_call_req && !i_rfd && i_cp_valid && cpd_w == xscc_pkg::CP_WAIT && !fr_go
		|-> cc_code == xscc_pkg::CC_CP ##1 tmr_reg == CPW_CYC)
		else $error("wait class cp mishandled");
	AST_RETRY: assert property (
		o_call_req && !i_rfd && i_cp_valid && cpd_w == xscc_pkg::CP_RETRY_B && !fr_go
		|-> cc_code == xscc_pkg::CC_RETRY ##1 o_clear_req && cpb_reg == $past(i_cp_code))
		else $error("retry cp mishandled");
	AST_DIAL: assert property (
		lc_reg == LC_READY && key_w[xscc_pkg::K_DIAL] && !cc_v
		|=> o_home_cursor && o_ind[xscc_pkg::I_WAIT])
		else $error("dial key mishandled");
	AST_LINK_DISCONNECT_KEY: assert property (
		lc_reg == LC_DATA && i_link_disconnect_key |=> lc_reg == LC_DISCONNECT_KEY)
		else $error("link disconnect ignored");
	AST_IGN_DISCONNECT_KEY: assert property (
		lc_reg == LC_READY && key_w == 6'h04 && !cc_v |=> lc_reg == LC_READY)
		else $error("disconnect key not ignored in ready");
endmodule : xscc_top
`default_nettype wire

// ===== test/tb.sv
// testbench for the x21 switched call control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// signals
	// ----------
	typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} xscc_row_t;
	localparam int M_CREQ = 9;
	localparam int M_CLR = 10;
	localparam int M_DATA = 11;
	localparam int M_CNR = 12;
	localparam int M_ACC = 13;
	localparam int M_SEL = 14;
	logic clk, rst, hsel, hwrite, dce, slow, cmp_err;
	logic [31:0] haddr, hwdata, rd, hrdata, sel_data;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] cmd;
	logic [7:0] code, cpc;
	logic hready, hresp, creq, cacc, sel_en, clr, arst, cnr, dph, hc, bell, rfd, cpv, cdone;
	logic [8:0] ind;
	logic [14:0] mon;
	int bad_count = 0;
	int n_checks = 0;
	int rst_cnt = 0;
	int hc_cnt = 0;
	int n0;
	xscc_row_t rows [6] = '{
		'{xscc_pkg::OFS_SEL, 32'hA5C3_0F96, 32'hA5C3_0F96},
		'{xscc_pkg::OFS_SEL, 32'h0000_0000, 32'h0000_0000},
		'{xscc_pkg::OFS_CFG, 32'h0000_0000, 32'h0000_0000},
		'{xscc_pkg::OFS_CFG, 32'h0000_0001, 32'h0000_0001},
		'{xscc_pkg::OFS_KEY, 32'h0000_0000, 32'h0000_0000},
		'{8'h20, 32'hFFFF_FFFF, 32'h0000_0000}};
	assign mon = {sel_en, cacc, cnr, dph, clr, creq, ind};
	always @(posedge clk) begin
		if (arst === 1'b1) rst_cnt++;
		if (hc === 1'b1) hc_cnt++;
	end
	// ----------
	// instances
	// ----------
	xscc_top #(.RFD_CYC(40), .CPW_CYC(200), .CLR_CYC(40)) i_xscc_top (
		.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_dce_ready(dce),
		.i_bell(bell), .i_rfd(rfd), .i_cp_valid(cpv), .i_cp_code(cpc), .i_clear_done(cdone),
		.i_cmp_err(cmp_err), .i_link_disconnect_key(cmd[3]), .i_link_tmo(cmd[4]), .o_call_req(creq),
		.o_call_acc(cacc), .o_sel_en(sel_en), .o_sel_data(sel_data), .o_clear_req(clr),
		.o_adapter_rst(arst), .o_cnr(cnr), .o_data_phase(dph), .o_ind(ind), .o_home_cursor(hc));
	xscc_dce_model i_xscc_dce_model (
		.i_ref_clk(clk), .i_rst(rst), .i_cmd(cmd[2:0]), .i_code(code), .i_slow(slow),
		.i_call_req(creq), .i_call_acc(cacc), .i_clear_req(clr), .i_data_phase(dph),
		.o_bell(bell), .o_rfd(rfd), .o_cp_valid(cpv), .o_cp_code(cpc), .o_clear_done(cdone));
	// ----------
	// tasks
	// ----------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_checks++;
		if (seen !== ex) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, seen);
		end
	endtask : check
	task wm(input string nm, input int idx, input logic v, input int lim);
		int k;
		k = 0;
		@(negedge clk);
		while (mon[idx] !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
		check(nm, {31'h0, mon[idx]}, {31'h0, v});
	endtask : wm
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= xscc_pkg::SZ_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task key(input int b);
		ahb(1'b1, xscc_pkg::OFS_KEY, 32'h0000_0001 << b);
	endtask : key
	task go(input int w, input logic [7:0] c);
		@(posedge clk);
		cmd[w] <= 1'b1;
		code <= c;
		@(posedge clk);
		cmd[w] <= 1'b0;
	endtask : go
	task do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		@(negedge clk);
		check("reset cnr", {31'h0, cnr}, 32'h0000_0001);
		check("reset ind", {23'h0, ind}, 32'h0000_0000);
		check("reset hready", {31'h0, hready}, 32'h0000_0001);
		check("reset hresp", {31'h0, hresp}, 32'h0000_0000);
		@(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// ----------
	// clock, watchdog, sequence
	// ----------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		test_done;
	end
	initial begin
		rst = 1'b1;
		{hsel, hwrite, slow, cmp_err} = 4'h0;
		dce = 1'b1;
		{haddr, hwdata} = 64'h0;
		{htrans, hsize, cmd, code} = 18'h00000;
		do_reset;
		wm("ready", xscc_pkg::I_READY, 1'b1, 500);
		wm("cnr off", M_CNR, 1'b0, 0);
		ahb(1'b0, xscc_pkg::OFS_CFG, 32'h0);
		check("cfg reset", rd, 32'h0000_0001);
		ahb(1'b0, xscc_pkg::OFS_STAT, 32'h0);
		check("status", rd & 32'h0000_C1FF, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			ahb(1'b1, rows[i].a, rows[i].wd);
			ahb(1'b0, rows[i].a, 32'h0);
			check("register", rd, rows[i].ex);
		end
		// disconnect key ignored in call ready
		key(xscc_pkg::K_DISCONNECT_KEY);
		repeat (20) @(negedge clk);
		wm("disconnect_key ignored", M_CLR, 1'b0, 0);
		wm("still ready", xscc_pkg::I_READY, 1'b1, 0);
		// incoming call, then disconnect key
		go(0, 8'h00);
		wm("call accepted", M_ACC, 1'b1, 50);
		wm("incoming ind", xscc_pkg::I_IN, 1'b1, 50);
		ahb(1'b0, xscc_pkg::OFS_STAT, 32'h0);
		check("bell status", {29'h0, rd[18:16]}, {29'h0, xscc_pkg::CC_BEL});
		go(1, 8'h00);
		wm("data phase", M_DATA, 1'b1, 50);
		wm("in use", xscc_pkg::I_USE, 1'b1, 50);
		wm("incoming off", xscc_pkg::I_IN, 1'b0, 0);
		key(xscc_pkg::K_COMM);
		repeat (5) @(negedge clk);
		wm("comm ignored", M_DATA, 1'b1, 0);
		n0 = rst_cnt;
		key(xscc_pkg::K_DISCONNECT_KEY);
		wm("disconnect_key ind", xscc_pkg::I_DISCONNECT_KEY, 1'b1, 50);
		wm("close cnr", M_CNR, 1'b1, 200);
		check("adapter reset", {31'h0, rst_cnt != n0}, 32'h0000_0001);
		wm("ready again", xscc_pkg::I_READY, 1'b1, 500);
		wm("in use off", xscc_pkg::I_USE, 1'b0, 0);
		// direct calls dropped by link disconnect, then by link timeout
		for (int e = 0; e < 2; e++) begin
			key(xscc_pkg::K_DIRECT);
			wm("call req", M_CREQ, 1'b1, 200);
			wm("no selection", M_SEL, 1'b0, 0);
			wm("outgoing ind", xscc_pkg::I_OUT, 1'b1, 0);
			go(1, 8'h00);
			wm("data phase", M_DATA, 1'b1, 50);
			wm("in use", xscc_pkg::I_USE, 1'b1, 50);
			wm("outgoing off", xscc_pkg::I_OUT, 1'b0, 0);
			go(3 + e, 8'h00);
			wm("line dropped", M_DATA, 1'b0, 300);
			// second drop meets a comparator error while clearing
			@(posedge clk);
			cmp_err <= e[0];
			@(posedge clk);
			cmp_err <= 1'b0;
			wm("ready", xscc_pkg::I_READY, 1'b1, 500);
			wm("reminder", xscc_pkg::I_CERR, e[0], 0);
			ahb(1'b0, xscc_pkg::OFS_STAT, 32'h0);
			check("close code", {29'h0, rd[18:16]},
				{29'h0, e ? xscc_pkg::CC_ERROR : xscc_pkg::CC_NORMAL});
		end
		// dialled call rejected by a retry code
		n0 = hc_cnt;
		key(xscc_pkg::K_DIAL);
		wm("wait ind", xscc_pkg::I_WAIT, 1'b1, 50);
		wm("dial ind", xscc_pkg::I_DIAL, 1'b1, 200);
		check("home cursor", hc_cnt - n0, 32'h0000_0001);
		ahb(1'b1, xscc_pkg::OFS_SEL, 32'h0000_1234);
		key(xscc_pkg::K_ENTER);
		wm("call req", M_CREQ, 1'b1, 200);
		wm("selection", M_SEL, 1'b1, 0);
		check("sel data", sel_data, 32'h0000_1234);
		wm("outgoing ind", xscc_pkg::I_OUT, 1'b1, 0);
		go(2, 8'h21);
		wm("retry clear", M_CLR, 1'b1, 10);
		ahb(1'b0, xscc_pkg::OFS_CPB, 32'h0);
		check("cp buffer", rd, 32'h0000_0021);
		wm("ready", xscc_pkg::I_READY, 1'b1, 500);
		// wait class code stretches the ready for data timeout
		key(xscc_pkg::K_DIRECT);
		wm("call req", M_CREQ, 1'b1, 200);
		go(2, 8'h01);
		ahb(1'b0, xscc_pkg::OFS_STAT, 32'h0);
		check("cp status", {29'h0, rd[18:16]}, {29'h0, xscc_pkg::CC_CP});
		repeat (100) @(negedge clk);
		wm("long wait", M_CREQ, 1'b1, 0);
		wm("no clear", M_CLR, 1'b0, 0);
		go(2, 8'h45);
		repeat (5) @(negedge clk);
		wm("plain code", M_CREQ, 1'b1, 0);
		ahb(1'b0, xscc_pkg::OFS_CPB, 32'h0);
		check("cp buffer", rd, 32'h0000_0045);
		go(2, 8'h61);
		wm("retry clear", M_CLR, 1'b1, 10);
		wm("ready", xscc_pkg::I_READY, 1'b1, 500);
		// local mode with a slow clear
		slow <= 1'b1;
		key(xscc_pkg::K_LOCAL);
		wm("local ind", xscc_pkg::I_LOCAL, 1'b1, 100);
		wm("ready off", xscc_pkg::I_READY, 1'b0, 0);
		wm("halt cleared", M_CLR, 1'b0, 200);
		key(xscc_pkg::K_DISCONNECT_KEY);
		repeat (20) @(negedge clk);
		wm("disconnect_key ignored", xscc_pkg::I_LOCAL, 1'b1, 0);
		wm("local cnr", M_CNR, 1'b1, 0);
		wm("no clear", M_CLR, 1'b0, 0);
		key(xscc_pkg::K_COMM);
		wm("ready", xscc_pkg::I_READY, 1'b1, 500);
		wm("local off", xscc_pkg::I_LOCAL, 1'b0, 0);
		// dce not ready at power up
		@(posedge clk);
		slow <= 1'b0;
		dce <= 1'b0;
		do_reset;
		wm("reminder", xscc_pkg::I_CERR, 1'b1, 200);
		wm("not ready yet", xscc_pkg::I_READY, 1'b0, 0);
		@(posedge clk);
		dce <= 1'b1;
		wm("ready", xscc_pkg::I_READY, 1'b1, 500);
		test_done;
	end
endmodule : tb
`default_nettype wire

// ===== test/xscc_dce_model.sv
// network dce partner model for the call control bench
`default_nettype none
module xscc_dce_model (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// bench commands: bit0 bell, bit1 ready for data, bit2 call progress
	input wire logic [2:0] i_cmd,
	input wire logic [7:0] i_code,
	input wire logic i_slow,
	// design line outputs
	input wire logic i_call_req,
	input wire logic i_call_acc,
	input wire logic i_clear_req,
	input wire logic i_data_phase,
	// line status toward the design
	output logic o_bell,
	output logic o_rfd,
	output logic o_cp_valid,
	output logic [7:0] o_cp_code,
	output logic o_clear_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 6'h00;
			o_bell <= 1'b0;
			o_rfd <= 1'b0;
			o_cp_valid <= 1'b0;
			o_cp_code <= 8'h00;
			o_clear_done <= 1'b0;
		end else begin
			// clearing confirmed after a short or a long delay
			if (!i_clear_req) begin
				cnt <= 6'h00;
				o_clear_done <= 1'b0;
			end else if (cnt == (i_slow ? 6'h14 : 6'h05)) begin
				o_clear_done <= 1'b1;
			end else begin
				cnt <= cnt + 6'h01;
			end
			// incoming call held until accepted, a call request wins
			if (i_cmd[0] && !i_call_req) begin
				o_bell <= 1'b1;
			end else if (i_call_acc || i_call_req) begin
				o_bell <= 1'b0;
			end
			if (i_cmd[1]) begin
				o_rfd <= 1'b1;
			end else if (i_data_phase || i_clear_req) begin
				o_rfd <= 1'b0;
			end
			// code lines invert their previous value every cycle outside a call progress pulse
			o_cp_valid <= i_cmd[2];
			o_cp_code <= i_cmd[2] ? i_code : ~o_cp_code;
		end
	end
endmodule : xscc_dce_model
`default_nettype wire
